// File: core/rcr_pkg.sv
// package: register map, fields, states and timing of reset cause and remap
package rcr_pkg;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [31:0] REMAP_ADDR = 32'hffff0220;
  localparam logic [31:0] CAUSE_STATUS_ADDR = 32'hffff0230;
  localparam logic [31:0] CAUSE_CLEAR_ADDR = 32'hffff0234;
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'hffff0238;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'hffff023c;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int REMAP_BIT = 0;
  localparam int POR_BIT = 0;
  localparam int WDT_BIT = 1;
  localparam int SW_BIT = 2;
  localparam int CAUSE_W = 3;
  localparam int IRQ_REMAP_BIT = 0;
  localparam int IRQ_BOOT_BIT = 1;
  localparam int IRQ_BADCLR_BIT = 2;
  localparam int IRQ_W = 3;
  localparam logic [7:0] REMAP_RESET = 8'h00;
  localparam logic [2:0] CAUSE_RESET = 3'h0;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;

  // ****************************************
  // address map of the low region
  // ****************************************
  localparam logic [31:0] RESET_VECTOR = 32'h00000000;
  localparam logic [31:0] VECTOR_END = 32'h00000020;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int RST_HOLD_NS = 100;
  localparam int RST_HOLD_CYCLES = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [4:0] {
    BOOT_HOLD = 5'b00001,
    BOOT_KERNEL = 5'b00010,
    BOOT_LOADER = 5'b00100,
    BOOT_VECTOR = 5'b01000,
    BOOT_RUN = 5'b10000
  } rcr_boot_state_t;

  typedef struct packed {
    logic sw;
    logic wdt;
    logic por;
  } rcr_cause_t;

  typedef struct packed {
    logic remap;
    logic status;
    logic clear;
    logic istat;
    logic imask;
  } rcr_dec_t;

endpackage

// File: core/rcr_reset_stretch.sv
// module: stretches any reset trigger into a system reset of at least HOLD cycles
`timescale 1ns/100ps
`default_nettype none
module rcr_reset_stretch
  import rcr_pkg::*;
#(
  parameter int HOLD = RST_HOLD_CYCLES
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // trigger in, reset out
  input wire logic trigger,
  output logic hold_active
);

  localparam int CW = $clog2(HOLD + 1);
  localparam logic [CW-1:0] HOLD_CNT = CW'(HOLD);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  // a fresh trigger restarts the full hold
  assign cnt_next = trigger ? HOLD_CNT :
                    (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
  assign hold_active = (cnt_reg != '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= HOLD_CNT;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule
`default_nettype wire

// File: core/rcr_top.sv
// module: reset cause recording, reset request and low memory remap
`timescale 1ns/100ps
`default_nettype none
module rcr_top
  import rcr_pkg::*;
#(
  parameter int HOLD = RST_HOLD_CYCLES,
  parameter logic [31:0] LOW_END = VECTOR_END
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // reset sources
  input wire logic ext_reset_n,
  input wire logic wdt_timeout,
  // boot control
  input wire logic boot_mode_select_pin,
  input wire logic kernel_done,
  output logic sys_rst_n,
  output logic kernel_run,
  output logic loader_mode,
  output logic vector_jump,
  output logic [31:0] vector_addr,
  // low region decode
  input wire logic [31:0] cpu_addr,
  output logic remap_sram,
  output logic low_hit,
  output logic low_to_sram,
  output logic low_to_flash,
  // interrupt
  output logic irq
);

  // ****************************************
  // helper functions
  // ****************************************
  function automatic logic addr_is(input logic [31:0] a,
                                   input logic [31:0] b);
    addr_is = (a == b);
  endfunction

  function automatic logic in_low(input logic [31:0] a,
                                  input logic [31:0] last);
    in_low = (a >= RESET_VECTOR) && (a <= last);
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic remap_reg;
  logic remap_next;
  rcr_cause_t cause_reg;
  rcr_cause_t cause_next;
  logic por_pending_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_mask_next;
  rcr_boot_state_t boot_reg;
  rcr_boot_state_t boot_next;
  logic boot_pin_reg;
  logic boot_pin_next;
  logic sys_rst_n_reg;
  logic vector_jump_reg;

  // ****************************************
  // bus decode
  // ****************************************
  rcr_dec_t dec;
  wire req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire wr_lo = req & wb_we_i & wb_sel_i[0];
  wire rd = req & ~wb_we_i;
  wire [7:0] wbyte = wb_dat_i[7:0];

  assign dec.remap = addr_is(wb_adr_i, REMAP_ADDR);
  assign dec.status = addr_is(wb_adr_i, CAUSE_STATUS_ADDR);
  assign dec.clear = addr_is(wb_adr_i, CAUSE_CLEAR_ADDR);
  assign dec.istat = addr_is(wb_adr_i, IRQ_STATUS_ADDR);
  assign dec.imask = addr_is(wb_adr_i, IRQ_MASK_ADDR);

  wire remap_wr = wr_lo & dec.remap;
  wire status_wr = wr_lo & dec.status;
  wire clear_wr = wr_lo & dec.clear;
  wire istat_wr = wr_lo & dec.istat;
  wire imask_wr = wr_lo & dec.imask;

  assign ack_next = req;

  // ****************************************
  // reset sources and system reset
  // ****************************************
  logic hold_active;
  wire [CAUSE_W-1:0] cause_bits = cause_reg;
  wire [CAUSE_W-1:0] clr_bits = clear_wr ? wbyte[CAUSE_W-1:0] : '0;

  wire sw_reset = status_wr & wbyte[SW_BIT];
  // clear that misses a set bit
  wire bad_clear = clear_wr & (|(cause_bits & ~wbyte[CAUSE_W-1:0]));
  // any source restarts the system reset
  wire reset_trigger = ~ext_reset_n | wdt_timeout | sw_reset | bad_clear;

  rcr_reset_stretch #(
    .HOLD(HOLD)
  ) u_stretch (
    .clk(clk),
    .rst_n(rst_n),
    .trigger(reset_trigger),
    .hold_active(hold_active)
  );

  // ****************************************
  // reset cause register
  // ****************************************
  rcr_cause_t cause_set;

  assign cause_set.por = por_pending_reg;
  assign cause_set.wdt = wdt_timeout;
  assign cause_set.sw = sw_reset;

  // only the clear register removes a cause, set wins
  assign cause_next = rcr_cause_t'((cause_bits & ~clr_bits) | cause_set);

  // ****************************************
  // remap control
  // ****************************************
  // any system reset restores the program array low
  // write one maps sram low, write zero restores
  assign remap_next = hold_active ? REMAP_RESET[REMAP_BIT] :
                      remap_wr ? wbyte[REMAP_BIT] : remap_reg;
  wire remap_chg = remap_wr & ~hold_active &
                   (wbyte[REMAP_BIT] != remap_reg);

  // low region spans the exception vectors
  assign low_hit = in_low(cpu_addr, LOW_END);
  assign low_to_sram = low_hit & remap_reg;
  assign low_to_flash = low_hit & ~remap_reg;
  assign remap_sram = remap_reg;

  // ****************************************
  // boot sequence
  // ****************************************
  // pin is caught while the system reset is held
  assign boot_pin_next = hold_active ? boot_mode_select_pin : boot_pin_reg;

  // pin high: kernel first, then the reset vector; pin low: the loader, with no vector jump
  always_comb begin
    boot_next = boot_reg;
    case (boot_reg)
      BOOT_HOLD: begin
        if (!hold_active) begin
          boot_next = boot_pin_reg ? BOOT_KERNEL : BOOT_LOADER;
        end
      end
      BOOT_KERNEL: begin
        if (kernel_done) begin
          boot_next = BOOT_VECTOR;
        end
      end
      BOOT_LOADER: begin
        boot_next = BOOT_LOADER;
      end
      BOOT_VECTOR: begin
        boot_next = BOOT_RUN;
      end
      BOOT_RUN: begin
        boot_next = BOOT_RUN;
      end
      default: begin
        boot_next = BOOT_HOLD;
      end
    endcase
    if (hold_active) begin
      boot_next = BOOT_HOLD;
    end
  end

  assign kernel_run = (boot_reg == BOOT_KERNEL);
  assign loader_mode = (boot_reg == BOOT_LOADER);
  assign vector_jump = vector_jump_reg;
  assign vector_addr = RESET_VECTOR;
  assign sys_rst_n = sys_rst_n_reg;

  // ****************************************
  // interrupt status and mask
  // ****************************************
  logic [IRQ_W-1:0] irq_set;
  assign irq_set[IRQ_REMAP_BIT] = remap_chg;
  assign irq_set[IRQ_BOOT_BIT] = (boot_next == BOOT_VECTOR) &&
                                 (boot_reg == BOOT_KERNEL);
  assign irq_set[IRQ_BADCLR_BIT] = bad_clear;

  wire [IRQ_W-1:0] irq_clr = istat_wr ? wbyte[IRQ_W-1:0] : '0;
  assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
  assign irq_mask_next = imask_wr ? wbyte[IRQ_W-1:0] : irq_mask_reg;
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ****************************************
  // read data
  // ****************************************
  // pin reset sets no cause bit, earlier causes still read back
  // upper cause bits read zero, clear reads zero
  always_comb begin
    rdata_next = '0;
    if (rd) begin
      if (dec.remap) begin
        rdata_next[REMAP_BIT] = remap_reg;
      end else if (dec.status) begin
        rdata_next[CAUSE_W-1:0] = cause_bits;
      end else if (dec.istat) begin
        rdata_next[IRQ_W-1:0] = irq_stat_reg;
      end else if (dec.imask) begin
        rdata_next[IRQ_W-1:0] = irq_mask_reg;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // power-on marks a pending cause on release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_reg <= rcr_cause_t'(CAUSE_RESET);
      por_pending_reg <= 1'b1;
    end else begin
      cause_reg <= cause_next;
      por_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remap_reg <= REMAP_RESET[REMAP_BIT];
    end else begin
      remap_reg <= remap_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_reg <= BOOT_HOLD;
      boot_pin_reg <= 1'b0;
      vector_jump_reg <= 1'b0;
      sys_rst_n_reg <= 1'b0;
    end else begin
      boot_reg <= boot_next;
      boot_pin_reg <= boot_pin_next;
      vector_jump_reg <= (boot_next == BOOT_VECTOR);
      sys_rst_n_reg <= ~hold_active;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= IRQ_RESET;
      irq_mask_reg <= MASK_RESET;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

endmodule
`default_nettype wire

// File: verif/rcr_props.sv
// checker: port-level assertions for reset cause and remap
`timescale 1ns/100ps
`default_nettype none
module rcr_props
  import rcr_pkg::*;
#(
  parameter logic [31:0] LOW_END = VECTOR_END
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_ack_o,
  // resets and boot
  input wire logic ext_reset_n,
  input wire logic wdt_timeout,
  input wire logic kernel_done,
  input wire logic sys_rst_n,
  input wire logic kernel_run,
  input wire logic vector_jump,
  // decode
  input wire logic [31:0] cpu_addr,
  input wire logic remap_sram,
  input wire logic low_hit,
  input wire logic low_to_sram
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic quiet = sys_rst_n && ext_reset_n && !wdt_timeout;
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic wr0 = req && wb_we_i && wb_sel_i[0];
  sequence jump_s;
    vector_jump && !kernel_run ##1 !vector_jump;
  endsequence
  // ****************************************
  // properties
  // ****************************************
  ack_follows_req_a: assert property (req |=> wb_ack_o)
    else $error("ack missing after request");
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  remap_write_a: assert property (
    wr0 && wb_adr_i == REMAP_ADDR && quiet ##1 sys_rst_n
    |-> remap_sram == $past(wb_dat_i[0]))
    else $error("remap bit not taken");
  remap_cleared_a: assert property (!sys_rst_n |-> !remap_sram)
    else $error("remap set during reset");
  low_route_a: assert property (
    low_hit == (cpu_addr <= LOW_END) && low_to_sram == (low_hit && remap_sram))
    else $error("low region decode wrong");
  wdt_reset_a: assert property (wdt_timeout |=> ##1 !sys_rst_n)
    else $error("watchdog did not reset");
  ext_reset_a: assert property (!ext_reset_n |=> ##1 !sys_rst_n)
    else $error("pin did not reset");
  reset_hold_a: assert property ($fell(sys_rst_n) |-> !sys_rst_n[*3])
    else $error("system reset too short");
  boot_jump_a: assert property (
    kernel_run && kernel_done && quiet ##1 sys_rst_n |-> jump_s)
    else $error("no branch after kernel");
  sw_reset_a: assert property (
    wr0 && wb_adr_i == CAUSE_STATUS_ADDR && wb_dat_i[2] |=> ##1 !sys_rst_n)
    else $error("software reset missing");
endmodule
`default_nettype wire

// File: verif/tb.sv
// testbench: directed tests of the reset cause and remap block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rcr_pkg::*;
  logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, cpu_addr, vector_addr, q;
  logic [3:0] wb_sel_i;
  logic ext_reset_n, wdt_timeout, boot_mode_select_pin, kernel_done;
  logic sys_rst_n, kernel_run, loader_mode, vector_jump, irq;
  logic remap_sram, low_hit, low_to_sram, low_to_flash;
  int n_fail, comparisons, cycles;
  rcr_top #(.HOLD(3)) rcr_top_inst (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ext_reset_n(ext_reset_n), .wdt_timeout(wdt_timeout),
    .boot_mode_select_pin(boot_mode_select_pin), .kernel_done(kernel_done),
    .sys_rst_n(sys_rst_n), .kernel_run(kernel_run),
    .loader_mode(loader_mode), .vector_jump(vector_jump),
    .vector_addr(vector_addr), .cpu_addr(cpu_addr), .remap_sram(remap_sram),
    .low_hit(low_hit), .low_to_sram(low_to_sram),
    .low_to_flash(low_to_flash), .irq(irq));
  // ****************************************
  // helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic bus(input logic we, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    check(q, exp);
  endtask
  task automatic settle;
    int n;
    repeat (2) @(posedge clk);
    n = 0;
    while (sys_rst_n !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic probe(input logic [31:0] a);
    @(posedge clk);
    cpu_addr <= a;
    @(posedge clk);
    #1;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_power_on;
    rd(CAUSE_STATUS_ADDR, 32'h00000001);
    rd(REMAP_ADDR, 32'h00000000);
    rd(CAUSE_CLEAR_ADDR, 32'h00000000);
    rd(32'hffff0300, 32'h00000000);
    $display("power-on test done");
  endtask
  task automatic t_boot;
    settle();
    check(32'(kernel_run), 32'h00000001);
    @(posedge clk);
    kernel_done <= 1'b1;
    @(posedge clk);
    kernel_done <= 1'b0;
    #1;
    check(32'(vector_jump), 32'h00000001);
    check(vector_addr, 32'h00000000);
    rd(IRQ_STATUS_ADDR, 32'h00000002);
    wr(IRQ_MASK_ADDR, 32'h00000002);
    check(32'(irq), 32'h00000001);
    wr(IRQ_STATUS_ADDR, 32'h00000002);
    check(32'(irq), 32'h00000000);
    $display("boot test done");
  endtask
  task automatic t_remap;
    probe(32'h00080024);
    check(32'(low_hit), 32'h00000000);
    wr(REMAP_ADDR, 32'h00000001);
    rd(REMAP_ADDR, 32'h00000001);
    probe(32'h00000020);
    check(32'(low_to_sram), 32'h00000001);
    probe(32'h00000021);
    check(32'(low_hit), 32'h00000000);
    probe(32'h00080024);
    wr(REMAP_ADDR, 32'h00000000);
    probe(32'h00000000);
    check(32'(low_to_flash), 32'h00000001);
    wr(CAUSE_CLEAR_ADDR, 32'h00000001);
    rd(CAUSE_STATUS_ADDR, 32'h00000000);
    check(32'(sys_rst_n), 32'h00000001);
    $display("remap and clear test done");
  endtask
  task automatic t_sources;
    @(posedge clk);
    ext_reset_n <= 1'b0;
    boot_mode_select_pin <= 1'b0;
    @(posedge clk);
    ext_reset_n <= 1'b1;
    @(posedge clk);
    #1;
    check(32'(sys_rst_n), 32'h00000000);
    settle();
    check(32'(loader_mode), 32'h00000001);
    rd(CAUSE_STATUS_ADDR, 32'h00000000);
    wr(REMAP_ADDR, 32'h00000001);
    @(posedge clk);
    wdt_timeout <= 1'b1;
    @(posedge clk);
    wdt_timeout <= 1'b0;
    settle();
    rd(CAUSE_STATUS_ADDR, 32'h00000002);
    rd(REMAP_ADDR, 32'h00000000);
    wr(CAUSE_STATUS_ADDR, 32'h00000007);
    settle();
    rd(CAUSE_STATUS_ADDR, 32'h00000006);
    $display("reset source test done");
  endtask
  task automatic t_bad_clear;
    wr(CAUSE_CLEAR_ADDR, 32'h00000002);
    #1;
    check(32'(sys_rst_n), 32'h00000000);
    settle();
    rd(CAUSE_STATUS_ADDR, 32'h00000004);
    rd(IRQ_STATUS_ADDR, 32'h00000005);
    wr(IRQ_MASK_ADDR, 32'h00000004);
    check(32'(irq), 32'h00000001);
    wr(IRQ_STATUS_ADDR, 32'h00000005);
    check(32'(irq), 32'h00000000);
    wr(CAUSE_CLEAR_ADDR, 32'h00000004);
    rd(CAUSE_STATUS_ADDR, 32'h00000000);
    $display("bad clear test done");
  endtask
  initial begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 32'h00000000;
    wb_dat_i = 32'h00000000;
    wb_sel_i = 4'hf;
    ext_reset_n = 1'b1;
    wdt_timeout = 1'b0;
    boot_mode_select_pin = 1'b1;
    kernel_done = 1'b0;
    cpu_addr = 32'h00000000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_power_on();
    t_boot();
    t_remap();
    t_sources();
    t_bad_clear();
    finish_test();
  end
endmodule
bind rcr_top rcr_props #(.LOW_END(32'h00000020)) rcr_props_inst (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .ext_reset_n(ext_reset_n),
  .wdt_timeout(wdt_timeout), .kernel_done(kernel_done),
  .sys_rst_n(sys_rst_n), .kernel_run(kernel_run),
  .vector_jump(vector_jump), .cpu_addr(cpu_addr), .remap_sram(remap_sram),
  .low_hit(low_hit), .low_to_sram(low_to_sram));
`default_nettype wire
